// >>> src/epiu_top.sv
// external pin interrupt unit: sense control, pending flags, sleep wake-up and AXI4-Lite registers
// Functional notes
// - pins trigger even when driven as outputs
// - low level requests while pin stays low
// - edges detected only while I/O clock runs
// - low level detected without I/O clock
// - I/O clock stopped in non-idle sleep
// - deep wake needs two watchdog samples low
// - level gone before start-up ends: wake, no interrupt
// - line b sense field bits 3:2
// - line a sense field bits 1:0
// - pin sampled before edge detection
// - request needs line enable and global enable
// - each line has its own vector request
// - trigger sets line pending flag bit
// - flag cleared by vector entry or one-write
// - flag reads zero in low-level mode
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module epiu_top
  import epiu_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        ext_irq_line_a,
  input  wire logic        ext_irq_line_b,
  input  wire logic        cpu_status_word_i,
  input  wire logic        vector_ack_a,
  input  wire logic        vector_ack_b,
  input  wire logic        sleep_cmd,
  output logic             vector_req_a,
  output logic             vector_req_b,
  output logic             io_clk_run,
  output logic             cpu_asleep,
  output logic             irq
);

  // ==========================================================================
  // register state
  logic [7:0]           sense_ff;
  logic [7:0]           enable_ff;
  logic [NUM_LINES-1:0] pending_ff;
  logic [EVT_WIDTH-1:0] evt_stat_ff;
  logic [EVT_WIDTH-1:0] evt_en_ff;
  epiu_sleep_t          sleep_ff;
  logic [WDT_CW-1:0]    wdt_cnt_ff;
  logic [START_CW-1:0]  start_cnt_ff;
  logic [NUM_LINES-1:0] prev_ff;
  logic [NUM_LINES-1:0] req_ff;

  logic [NUM_LINES-1:0] pin_raw;
  logic [NUM_LINES-1:0] pin_sync;
  logic [NUM_LINES-1:0] line_en;
  logic [NUM_LINES-1:0] ack;
  logic [NUM_LINES-1:0] level_mode;
  logic [NUM_LINES-1:0] trig;
  logic [NUM_LINES-1:0] lvl_wake;
  logic [NUM_LINES-1:0] nxt_req;
  logic [NUM_LINES-1:0] w1c_pending;
  logic [EVT_WIDTH-1:0] evt_set;
  logic [EVT_WIDTH-1:0] evt_clr;
  logic                 wdt_tick;
  logic                 any_lvl_wake;
  logic                 wake_deep;
  logic                 wake_noirq;

  // pad levels are sensed whatever the pin direction, so software can drive them
  assign pin_raw = {ext_irq_line_b, ext_irq_line_a};
  assign line_en = {enable_ff[ENABLE_B_BIT], enable_ff[ENABLE_A_BIT]};
  assign ack     = {vector_ack_b, vector_ack_a};

  // ==========================================================================
  // pin sampling
  epiu_sync2 u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     (pin_raw),
    .dout    (pin_sync)
  );

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prev_ff <= '1;
    else
      prev_ff <= pin_sync;
  end

  // ==========================================================================
  // per-line sense decode
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++)
    begin : g_line
      logic [1:0] mode;
      logic       rise;
      logic       fall;

      // line a uses bits 1:0, line b bits 3:2
      assign mode = sense_ff[SENSE_A_LO + 2*gi +: 2];
      assign rise = pin_sync[gi] & ~prev_ff[gi];
      assign fall = ~pin_sync[gi] & prev_ff[gi];
      assign level_mode[gi] = (mode == SENSE_LOW);

      // edges need the I/O clock; a stopped clock loses them
      always_comb
      begin
        trig[gi] = 1'b0;
        if (io_clk_run)
        begin
          unique case (mode)
            SENSE_LOW:  trig[gi] = 1'b0;
            SENSE_ANY:  trig[gi] = rise | fall;
            SENSE_FALL: trig[gi] = fall;
            SENSE_RISE: trig[gi] = rise;
          endcase
        end
      end

      // the low level path uses the raw pad and no clock gating
      assign lvl_wake[gi] = level_mode[gi] & ~pin_raw[gi] & line_en[gi] & cpu_status_word_i;

      always_comb
      begin
        nxt_req[gi] = 1'b0;
        if (cpu_status_word_i && line_en[gi] && io_clk_run)
        begin
          if (level_mode[gi])
            nxt_req[gi] = ~pin_sync[gi];
          else
            nxt_req[gi] = pending_ff[gi];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // pending flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pending_ff <= '0;
    else
      // a trigger in the clearing cycle wins; level mode keeps the flag at zero
      pending_ff <= ~level_mode & (trig | (pending_ff & ~ack & ~w1c_pending));
  end

  // one request line per vector
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      req_ff <= '0;
    else
      req_ff <= nxt_req & ~ack;
  end

  assign vector_req_a = req_ff[0];
  assign vector_req_b = req_ff[1];

  // ==========================================================================
  // sleep control and wake-up qualification
  assign any_lvl_wake = |lvl_wake;
  assign wdt_tick     = (wdt_cnt_ff == WDT_LAST);
  assign io_clk_run   = (sleep_ff == SL_RUN) || (sleep_ff == SL_IDLE);
  assign cpu_asleep   = (sleep_ff != SL_RUN);
  assign wake_deep    = (sleep_ff == SL_START) && (start_cnt_ff == START_LAST);
  assign wake_noirq   = wake_deep && !any_lvl_wake;

  // watchdog oscillator stand-in, free running
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wdt_cnt_ff <= '0;
    else if (wdt_tick)
      wdt_cnt_ff <= '0;
    else
      wdt_cnt_ff <= wdt_cnt_ff + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      start_cnt_ff <= '0;
    else if (sleep_ff == SL_START)
      start_cnt_ff <= start_cnt_ff + 1'b1;
    else
      start_cnt_ff <= '0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sleep_ff <= SL_RUN;
    else
    begin
      unique case (sleep_ff)
        SL_RUN:
          if (sleep_cmd && sense_ff[SLEEP_ALLOW])
          begin
            if (sense_ff[SLEEP_SEL_LO +: 3] == SLEEP_IDLE)
              sleep_ff <= SL_IDLE;
            else
              sleep_ff <= SL_DEEP;
          end
        SL_IDLE:
          if (|nxt_req)
            sleep_ff <= SL_RUN;
        SL_DEEP:
          if (wdt_tick && any_lvl_wake)
            sleep_ff <= SL_QUAL;
        SL_QUAL:
          if (wdt_tick)
            sleep_ff <= any_lvl_wake ? SL_START : SL_DEEP;
        SL_START:
          // wake after start-up even if the level went away meanwhile
          if (wake_deep)
            sleep_ff <= SL_RUN;
      endcase
    end
  end

  // ==========================================================================
  // event status, enable and interrupt
  assign evt_set = {wake_noirq, wake_deep, trig[1], trig[0]};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_stat_ff <= '0;
    else
      evt_stat_ff <= evt_set | (evt_stat_ff & ~evt_clr);
  end

  assign irq = |(evt_stat_ff & evt_en_ff);

  // ==========================================================================
  // AXI4-Lite write channel
  logic [7:0]  aw_addr_ff;
  logic        aw_have_ff;
  logic [31:0] w_data_ff;
  logic        w_lane0_ff;
  logic        w_have_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        wr_fire;
  logic        wr_en;
  logic        wr_hit;

  assign s_axi_awready = !aw_have_ff && !bvalid_ff;
  assign s_axi_wready  = !w_have_ff && !bvalid_ff;
  assign wr_fire       = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_en         = wr_fire && w_lane0_ff;

  always_comb
  begin
    unique case (aw_addr_ff)
      ADDR_SENSE, ADDR_ENABLE, ADDR_FLAGS, ADDR_EVT_STAT,
      ADDR_EVT_EN, ADDR_EVT_CLR, ADDR_SLP_STAT: wr_hit = 1'b1;
      default:                                  wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_have_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_ff  <= 1'b0;
      w_data_ff  <= '0;
      w_lane0_ff <= 1'b0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_ff  <= 1'b1;
      w_data_ff  <= s_axi_wdata;
      w_lane0_ff <= s_axi_wstrb[0];
    end
    else if (wr_fire)
      w_have_ff <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sense_ff <= SENSE_RST;
    else if (wr_en && aw_addr_ff == ADDR_SENSE)
      sense_ff <= w_data_ff[7:0];
  end

  // vector-select bits are not kept here and read as zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      enable_ff <= ENABLE_RST;
    else if (wr_en && aw_addr_ff == ADDR_ENABLE)
      enable_ff <= w_data_ff[7:0] & ENABLE_MASK;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      evt_en_ff <= '0;
    else if (wr_en && aw_addr_ff == ADDR_EVT_EN)
      evt_en_ff <= w_data_ff[EVT_WIDTH-1:0];
  end

  assign w1c_pending = (wr_en && aw_addr_ff == ADDR_FLAGS) ?
                       {w_data_ff[PENDING_B_BIT], w_data_ff[PENDING_A_BIT]} : '0;
  assign evt_clr     = (wr_en && aw_addr_ff == ADDR_EVT_CLR) ? w_data_ff[EVT_WIDTH-1:0] : '0;

  // ==========================================================================
  // AXI4-Lite read channel
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rd_mux;
  logic        rd_hit;

  assign s_axi_arready = !rvalid_ff;

  always_comb
  begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_SENSE:    rd_mux[7:0] = sense_ff;
      ADDR_ENABLE:   rd_mux[7:0] = enable_ff;
      ADDR_FLAGS:
      begin
        rd_mux[PENDING_A_BIT] = pending_ff[0];
        rd_mux[PENDING_B_BIT] = pending_ff[1];
      end
      ADDR_EVT_STAT: rd_mux[EVT_WIDTH-1:0] = evt_stat_ff;
      ADDR_EVT_EN:   rd_mux[EVT_WIDTH-1:0] = evt_en_ff;
      ADDR_EVT_CLR:  rd_mux = '0;
      ADDR_SLP_STAT: rd_mux[2:0] = {1'b0, io_clk_run, cpu_asleep};
      default:       rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

endmodule // epiu_top

// >>> src/epiu_pkg.sv
// package: register map, field positions, modes and timing of the external pin interrupt unit
package epiu_pkg;

  // ==========================================================================
  // register byte addresses
  localparam logic [7:0] ADDR_SENSE     = 8'h00;
  localparam logic [7:0] ADDR_ENABLE    = 8'h04;
  localparam logic [7:0] ADDR_FLAGS     = 8'h08;
  localparam logic [7:0] ADDR_EVT_STAT  = 8'h0C;
  localparam logic [7:0] ADDR_EVT_EN    = 8'h10;
  localparam logic [7:0] ADDR_EVT_CLR   = 8'h14;
  localparam logic [7:0] ADDR_SLP_STAT  = 8'h18;

  // ==========================================================================
  // field positions and reset values
  localparam int NUM_LINES      = 2;
  localparam int SENSE_A_LO     = 0;
  localparam int SENSE_B_LO     = 2;
  localparam int SLEEP_SEL_LO   = 4;
  localparam int SLEEP_ALLOW    = 7;
  localparam int ENABLE_A_BIT   = 6;
  localparam int ENABLE_B_BIT   = 7;
  localparam int PENDING_A_BIT  = 6;
  localparam int PENDING_B_BIT  = 7;
  localparam int EVT_WIDTH      = 4;
  localparam int EVT_TRIG_A     = 0;
  localparam int EVT_TRIG_B     = 1;
  localparam int EVT_WAKE       = 2;
  localparam int EVT_WAKE_NOIRQ = 3;

  localparam logic [7:0] SENSE_RST  = 8'h00;
  localparam logic [7:0] ENABLE_RST = 8'h00;
  localparam logic [7:0] ENABLE_MASK = 8'hC0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // sense modes and sleep selection
  localparam logic [1:0] SENSE_LOW    = 2'h0;
  localparam logic [1:0] SENSE_ANY    = 2'h1;
  localparam logic [1:0] SENSE_FALL   = 2'h2;
  localparam logic [1:0] SENSE_RISE   = 2'h3;
  localparam logic [2:0] SLEEP_IDLE   = 3'h0;

  typedef enum logic [2:0] {
    SL_RUN,
    SL_IDLE,
    SL_DEEP,
    SL_QUAL,
    SL_START
  } epiu_sleep_t;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int WDT_PERIOD_US = 1;
  localparam int WDT_CYC       = (WDT_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int STARTUP_US    = 64;
  localparam int STARTUP_CYC   = (STARTUP_US * 1000) / CLK_PERIOD_NS;
  localparam int WDT_CW        = 6;
  localparam int START_CW      = 12;
  localparam logic [WDT_CW-1:0]   WDT_LAST   = WDT_CW'(WDT_CYC - 1);
  localparam logic [START_CW-1:0] START_LAST = START_CW'(STARTUP_CYC - 1);

endpackage

// >>> src/epiu_sync2.sv
// two-stage synchroniser for the interrupt pins
`timescale 1ns/1ps
module epiu_sync2
  import epiu_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [NUM_LINES-1:0] din,
  output logic      [NUM_LINES-1:0] dout
);

  // ==========================================================================
  // stages
  logic [NUM_LINES-1:0] stage1_ff;
  logic [NUM_LINES-1:0] stage2_ff;

  // first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1_ff <= '1;
      stage2_ff <= '1;
    end
    else
    begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
    end
  end

  assign dout = stage2_ff;

endmodule // epiu_sync2

// >>> test/epiu_top_properties.sv
// checker: bus handshakes, request gating and sleep relations at the unit's ports
`timescale 1ns/1ps
module epiu_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cpu_status_word_i,
  input wire logic        vector_ack_a,
  input wire logic        vector_ack_b,
  input wire logic        vector_req_a,
  input wire logic        vector_req_b,
  input wire logic        io_clk_run,
  input wire logic        cpu_asleep,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ==========================================================================
  // register bus
  chk_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response changed before it was taken");
  chk_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  chk_ar_refuse:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted with a read pending");
  chk_aw_refuse:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted with a response pending");
  chk_reset_quiet:
    assert property (disable iff (1'h0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !vector_req_a && !irq)
    else $error("outputs active after a reset edge");

  // ==========================================================================
  // requests and sleep
  chk_gie_rise_a:
    assert property ($rose(vector_req_a) |-> $past(cpu_status_word_i))
    else $error("request a raised with global enable off");
  chk_gie_rise_b:
    assert property ($rose(vector_req_b) |-> $past(cpu_status_word_i))
    else $error("request b raised with global enable off");
  chk_ack_drop_a:
    assert property (vector_ack_a |=> !vector_req_a)
    else $error("request a survived its vector entry");
  chk_ack_drop_b:
    assert property (vector_ack_b |=> !vector_req_b)
    else $error("request b survived its vector entry");
  chk_deep_quiet:
    assert property (!io_clk_run [*2] |-> !vector_req_a && !vector_req_b)
    else $error("request while the io clock is stopped");
  chk_awake_clock:
    assert property (!cpu_asleep |-> io_clk_run)
    else $error("io clock stopped while awake");
endmodule // epiu_checker

bind epiu_top epiu_checker u_chk (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cpu_status_word_i, .vector_ack_a,
  .vector_ack_b, .vector_req_a, .vector_req_b, .io_clk_run, .cpu_asleep, .irq);

// >>> test/epiu_pin_src.sv
// partner model: external sources driving the two interrupt pins
`timescale 1ns/1ps
module epiu_pin_src #(parameter int HOLD = 3) (
  input  wire logic       aclk,
  input  wire logic [1:0] want,
  output logic      [1:0] pin
);
  int hold_cnt = 0;
  initial pin = 2'h3;
  // a level is kept HOLD cycles at least, so no pulse is shorter than the sampler
  always @(posedge aclk)
  begin
    if (hold_cnt > 0)
      hold_cnt <= hold_cnt - 1;
    else if (want != pin)
    begin
      pin      <= want;
      hold_cnt <= HOLD;
    end
  end
endmodule // epiu_pin_src

// >>> test/external_pin_interrupt_unit_tb.sv
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
module external_pin_interrupt_unit_tb;
  import epiu_pkg::*;
  logic        aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, cpu_status_word_i = 1'h0, sleep_cmd = 1'h0;
  logic        vector_ack_a = 1'h0, vector_ack_b = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  want = 2'h3, s_axi_bresp, s_axi_rresp, reqs;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        vector_req_a, vector_req_b, io_clk_run, cpu_asleep, irq;
  wire logic   ext_irq_line_a, ext_irq_line_b;
  int          miscompares = 0, comparisons = 0, cyc = 0;
  assign reqs = {vector_req_b, vector_req_a};

  epiu_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_line_a, .ext_irq_line_b,
    .cpu_status_word_i, .vector_ack_a, .vector_ack_b, .sleep_cmd, .vector_req_a, .vector_req_b, .io_clk_run,
    .cpu_asleep, .irq);
  epiu_pin_src u_src (.aclk(aclk), .want(want), .pin({ext_irq_line_b, ext_irq_line_a}));

  initial
  begin
    forever #10 aclk = ~aclk;
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // handshakes are sampled at the falling edge, where the rising-edge values are settled
  // ready follows the answer by a cycle, so the hold checks see a stalled response
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb, tv;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    forever
    begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid & s_axi_bready;
      tv = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) break;
      if (tv) s_axi_bready <= 1'h1;
    end
    s_axi_bready <= 1'h0;
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr, tv;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    forever
    begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid & s_axi_rready;
      tv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) break;
      if (tv) s_axi_rready <= 1'h1;
    end
    s_axi_rready <= 1'h0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic drive(input int ln, input logic v);
    @(posedge aclk);
    want[ln] <= v;
    settle(10 + $urandom % 6);
  endtask

  task automatic done(input string s);
    $display("test %s ended", s);
  endtask

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      miscompares++;
      conclude();
    end
  end

  // ==========================================================================
  // scenarios
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    int hit;
    int n;
    void'($urandom(26));
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rc(ADDR_SENSE, SENSE_RST, RESP_OKAY);
    rc(ADDR_ENABLE, ENABLE_RST, RESP_OKAY);
    rc(8'h1C, 8'h00, RESP_SLVERR);
    wr(8'h1C, 8'hFF, RESP_SLVERR);
    wr(ADDR_ENABLE, 8'hFF, RESP_OKAY);
    rc(ADDR_ENABLE, ENABLE_MASK, RESP_OKAY);
    hit = $urandom;
    wr(ADDR_SENSE, 8'(hit), RESP_OKAY);
    rc(ADDR_SENSE, 8'(hit), RESP_OKAY);
    done("registers");
    cpu_status_word_i <= 1'h1;
    for (int ln = 0; ln < 2; ln++)
      for (int m = 1; m < 4; m++)
      begin
        wr(ADDR_SENSE, 8'(m << (2 * ln)), RESP_OKAY);
        for (int v = 0; v < 2; v++)
        begin
          hit = (m == 1) || (m == 2 && v == 0) || (m == 3 && v == 1);
          drive(ln, v[0]);
          chk(reqs[ln], hit[0]);
          rc(ADDR_FLAGS, 8'(hit << (6 + ln)), RESP_OKAY);
          if (v == 0)
            wr(ADDR_FLAGS, 8'hC0, RESP_OKAY);
          else
          begin
            @(posedge aclk);
            {vector_ack_b, vector_ack_a} <= 2'(1 << ln);
            @(posedge aclk);
            {vector_ack_b, vector_ack_a} <= 2'h0;
          end
          settle(1);
          chk(reqs[ln], 1'h0);
          rc(ADDR_FLAGS, 8'h00, RESP_OKAY);
        end
      end
    done("edge modes");
    wr(ADDR_SENSE, 8'h00, RESP_OKAY);
    @(posedge aclk);
    cpu_status_word_i <= 1'h0;
    drive(0, 1'h0);
    chk(vector_req_a, 1'h0);
    @(posedge aclk);
    cpu_status_word_i <= 1'h1;
    settle(20);
    chk(vector_req_a, 1'h1);
    rc(ADDR_FLAGS, 8'h00, RESP_OKAY);
    drive(0, 1'h1);
    chk(vector_req_a, 1'h0);
    done("low level");
    // idle sleep keeps the io clock, so a rising edge on line b still wakes the unit
    wr(ADDR_SENSE, 8'h8C, RESP_OKAY);
    @(posedge aclk);
    sleep_cmd <= 1'h1;
    @(posedge aclk);
    sleep_cmd <= 1'h0;
    rc(ADDR_SLP_STAT, 8'h03, RESP_OKAY);
    drive(1, 1'h0);
    chk(cpu_asleep, 1'h1);
    drive(1, 1'h1);
    chk({cpu_asleep, vector_req_b}, 2'h1);
    wr(ADDR_FLAGS, 8'h80, RESP_OKAY);
    chk(vector_req_b, 1'h0);
    done("idle sleep");
    wr(ADDR_EVT_EN, 8'h01, RESP_OKAY);
    rd(ADDR_EVT_STAT, d, r);
    chk(d & 32'h3, 32'h3);
    chk(irq, 1'h1);
    wr(ADDR_EVT_EN, 8'h00, RESP_OKAY);
    chk(irq, 1'h0);
    wr(ADDR_EVT_EN, 8'h01, RESP_OKAY);
    wr(ADDR_EVT_CLR, 8'h0F, RESP_OKAY);
    rc(ADDR_EVT_STAT, 8'h00, RESP_OKAY);
    chk(irq, 1'h0);
    done("event interrupt");
    for (int k = 0; k < 2; k++)
    begin
      wr(ADDR_EVT_CLR, 8'h0F, RESP_OKAY);
      wr(ADDR_SENSE, 8'h98, RESP_OKAY);
      @(posedge aclk);
      sleep_cmd <= 1'h1;
      @(posedge aclk);
      sleep_cmd <= 1'h0;
      settle(2);
      chk({cpu_asleep, io_clk_run}, 2'h2);
      drive(1, 1'h0);
      drive(0, 1'h0);
      if (k == 1)
      begin
        settle(150);
        drive(0, 1'h1);
      end
      n = 0;
      while (cpu_asleep === 1'h1 && n < 5000)
      begin
        @(negedge aclk);
        n++;
      end
      chk(cpu_asleep, 1'h0);
      rd(ADDR_EVT_STAT, d, r);
      chk(d & 32'hC, k ? 32'hC : 32'h4);
      settle(6);
      chk(vector_req_a, 1'(k == 0));
      rc(ADDR_FLAGS, 8'h00, RESP_OKAY);
      drive(0, 1'h1);
      drive(1, 1'h1);
    end
    done("deep sleep");
    conclude();
  end
endmodule // external_pin_interrupt_unit_tb
